/* core/adcc_top.sv */
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module adcc_top
  import adcc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        external_trigger_pin,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_result_i,
  output logic             conv_start,
  output logic [1:0]       conv_channel,
  output logic             converter_clock_select,
  output logic             irq
);

`include "adcc_params.svh"

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and trigger edge

  logic        wr_en;
  adcc_idx_t   reg_idx;
  logic [31:0] rdata;
  logic        trig_rise;

  adcc_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rdata     (rdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .reg_idx   (reg_idx)
  );

  adcc_trig_edge u_trig (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .external_trigger_pin (external_trigger_pin),
    .trig_rise            (trig_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer and control register

  adcc_state_e state_r, state_nxt;
  logic        done_r, done_nxt;
  logic        start_r, start_nxt;
  logic [1:0]  chan_r, chan_nxt;
  logic        clksel_r, clksel_nxt;
  logic        ext_en_r, ext_en_nxt;
  logic [9:0]  result_r, result_nxt;
  logic        busy;
  logic        wr_ctrl;
  logic        sw_start;
  logic        sw_clr;
  logic        hw_start;
  logic        refused;
  logic        finish;

  assign busy = (state_r == adcc_st_conv);

  // start acceptance, done flag, channel latch and result capture
  always_comb begin
    wr_ctrl    = wr_en & (reg_idx == `ADCC_IDX_CTRL);
    sw_start   = wr_ctrl & hwdata[`ADCC_CTRL_START];
    sw_clr     = wr_ctrl & ~hwdata[`ADCC_CTRL_DONE];
    hw_start   = ext_en_r & trig_rise;
    finish     = busy & conv_done_i;
    state_nxt  = state_r;
    done_nxt   = done_r;
    start_nxt  = 1'b0;
    chan_nxt   = chan_r;
    clksel_nxt = clksel_r;
    ext_en_nxt = ext_en_r;
    result_nxt = result_r;
    refused    = 1'b0;
    if (wr_ctrl) begin
      clksel_nxt = hwdata[`ADCC_CTRL_CLKSEL];
      ext_en_nxt = hwdata[`ADCC_CTRL_EXT_EN];
      // channel selection frozen unless idle with done clear
      if (!busy && !done_r) begin
        chan_nxt = hwdata[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
      end
      // writing one never sets done, writing zero clears it
      if (sw_clr) begin
        done_nxt = 1'b0;
      end
    end
    case (state_r)
      adcc_st_idle: begin
        // a clear in the same write opens the gate, channel kept
        if (sw_start && (!done_r || sw_clr)) begin
          state_nxt = adcc_st_conv;
          start_nxt = 1'b1;
        end else if (hw_start && !done_r) begin
          state_nxt = adcc_st_conv;
          start_nxt = 1'b1;
        end else begin
          refused = sw_start | hw_start;
        end
      end
      adcc_st_conv: begin
        // zero writes to start have no path here
        refused = sw_start | hw_start;
        if (finish) begin
          state_nxt  = adcc_st_idle;
          done_nxt   = 1'b1;
          result_nxt = conv_result_i;
        end
      end
      default: begin
        state_nxt = adcc_st_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= adcc_st_idle;
      done_r   <= 1'b0;
      start_r  <= 1'b0;
      chan_r   <= `ADCC_RST_CHAN;
      clksel_r <= `ADCC_RST_CLKSEL;
      ext_en_r <= `ADCC_RST_EXT_EN;
      result_r <= `ADCC_RST_RESULT;
    end else begin
      state_r  <= state_nxt;
      done_r   <= done_nxt;
      start_r  <= start_nxt;
      chan_r   <= chan_nxt;
      clksel_r <= clksel_nxt;
      ext_en_r <= ext_en_nxt;
      result_r <= result_nxt;
    end
  end

  // converter core sees the latched channel and clock choice
  assign conv_start             = start_r;
  assign conv_channel           = chan_r;
  assign converter_clock_select = clksel_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [`ADCC_IRQ_BITS-1:0] stat_r, stat_nxt;
  logic [`ADCC_IRQ_BITS-1:0] mask_r, mask_nxt;
  logic [`ADCC_IRQ_BITS-1:0] events;
  logic                      irq_r, irq_nxt;

  // set beats a write-one clear landing in the same cycle
  always_comb begin
    events                    = '0;
    events[`ADCC_IRQ_DONE]    = finish;
    events[`ADCC_IRQ_REFUSED] = refused;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_en && reg_idx == `ADCC_IDX_IRQ_STAT) begin
      stat_nxt = stat_r & ~hwdata[`ADCC_IRQ_BITS-1:0];
    end
    if (wr_en && reg_idx == `ADCC_IDX_IRQ_MASK) begin
      mask_nxt = hwdata[`ADCC_IRQ_BITS-1:0];
    end
    stat_nxt = stat_nxt | events;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= `ADCC_RST_IRQ;
      mask_r <= `ADCC_RST_IRQ;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped indexes read zero

  always_comb begin
    rdata = 32'h00000000;
    case (reg_idx)
      `ADCC_IDX_CTRL: begin
        rdata[`ADCC_CTRL_RES_HI]  = result_r[1];
        rdata[`ADCC_CTRL_RES_LO]  = result_r[0];
        rdata[`ADCC_CTRL_EXT_EN]  = ext_en_r;
        rdata[`ADCC_CTRL_DONE]    = done_r;
        rdata[`ADCC_CTRL_START]   = busy;
        rdata[`ADCC_CTRL_CLKSEL]  = clksel_r;
        rdata[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO] = chan_r;
      end
      `ADCC_IDX_RESH: begin
        rdata[7:0] = result_r[9:2];
      end
      `ADCC_IDX_IRQ_STAT: begin
        rdata[`ADCC_IRQ_BITS-1:0] = stat_r;
      end
      `ADCC_IDX_IRQ_MASK: begin
        rdata[`ADCC_IRQ_BITS-1:0] = mask_r;
      end
      default: begin
        rdata = 32'h00000000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sw_start_go_a: assert property (
    sw_start && !busy && !done_r |=> conv_start && busy)
    else $error("software start not accepted when idle");

  busy_hold_a: assert property (
    busy && !conv_done_i |=> busy)
    else $error("busy dropped before completion");

  done_ends_busy_a: assert property (
    busy && conv_done_i |=> !busy && done_r)
    else $error("completion did not set done and clear busy");

  busy_ignore_a: assert property (
    busy && !conv_done_i && wr_ctrl && !hwdata[3] |=> busy)
    else $error("zero write cleared busy");

  start_block_a: assert property (
    busy |=> !conv_start)
    else $error("start issued while busy");

  done_block_a: assert property (
    done_r && !sw_clr |=> !conv_start)
    else $error("start issued while done set");

  clear_start_a: assert property (
    done_r && !busy && sw_start && sw_clr |=> conv_start && $stable(chan_r))
    else $error("combined clear and start mishandled");

  chan_freeze_a: assert property (
    busy || done_r |=> $stable(chan_r))
    else $error("channel changed while busy or done");

  trig_start_a: assert property (
    !busy && !done_r && ext_en_r && trig_rise |=> conv_start)
    else $error("external trigger edge ignored");

  trig_off_a: assert property (
    !ext_en_r && !sw_start |=> !conv_start)
    else $error("start without enabled source");

  result_cap_a: assert property (
    busy && conv_done_i |=> result_r == $past(conv_result_i) && $rose(done_r))
    else $error("result not captured with done");

  done_no_sw_set_a: assert property (
    !done_r && !(busy && conv_done_i) |=> !done_r)
    else $error("done set without completion");

  irq_done_a: assert property (
    busy && conv_done_i && mask_r[0] && !(wr_en && reg_idx == `ADCC_IDX_IRQ_MASK) |=> irq)
    else $error("done interrupt not raised");

  idle_accept_a: assert property (
    !busy && !done_r && (sw_start || hw_start) |=> busy)
    else $error("idle start request not accepted");

  zero_write_a: assert property (
    !busy && wr_ctrl && !hwdata[`ADCC_CTRL_START] && !hw_start |=> !busy)
    else $error("zero write to start began a conversion");

  clksel_set_a: assert property (
    wr_ctrl && hwdata[`ADCC_CTRL_CLKSEL] |=> converter_clock_select)
    else $error("clock select one not applied");

  clksel_clr_a: assert property (
    wr_ctrl && !hwdata[`ADCC_CTRL_CLKSEL] |=> !converter_clock_select)
    else $error("clock select zero not applied");

  refused_flag_a: assert property (
    busy && (sw_start || hw_start) |=> stat_r[`ADCC_IRQ_REFUSED])
    else $error("start while busy not flagged");

  done_keep_a: assert property (
    done_r && !sw_clr |=> done_r)
    else $error("done dropped without software clear");

  done_clear_a: assert property (
    done_r && !busy && sw_clr |=> !done_r)
    else $error("software clear of done ignored");

  result_hold_a: assert property (
    !(busy && conv_done_i) |=> $stable(result_r))
    else $error("result changed outside completion");

endmodule

`default_nettype wire

/* core/adcc_params.svh */
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// register indexes; byte address is four times the index
`define ADCC_IDX_CTRL      8'hE1
`define ADCC_IDX_RESH      8'hE2
`define ADCC_IDX_IRQ_STAT  8'hE4
`define ADCC_IDX_IRQ_MASK  8'hE5

// control/status register fields
`define ADCC_CTRL_RES_HI   7
`define ADCC_CTRL_RES_LO   6
`define ADCC_CTRL_EXT_EN   5
`define ADCC_CTRL_DONE     4
`define ADCC_CTRL_START    3
`define ADCC_CTRL_CLKSEL   2
`define ADCC_CTRL_CH_HI    1
`define ADCC_CTRL_CH_LO    0

// interrupt status and mask fields
`define ADCC_IRQ_DONE      0
`define ADCC_IRQ_REFUSED   1
`define ADCC_IRQ_BITS      2

// reset values
`define ADCC_RST_CHAN      2'h0
`define ADCC_RST_CLKSEL    1'b0
`define ADCC_RST_EXT_EN    1'b0
`define ADCC_RST_RESULT    10'h000
`define ADCC_RST_IRQ       2'h0

// bus encodings
`define ADCC_HSIZE_WORD    3'h2
`define ADCC_HRESP_OKAY    1'b0

`endif

/* core/adcc_pkg.sv */
package adcc_pkg;

  // conversion sequencer states
  typedef enum logic [0:0] {
    adcc_st_idle = 1'b0,
    adcc_st_conv = 1'b1
  } adcc_state_e;

  typedef logic [7:0] adcc_idx_t;

endpackage

/* core/adcc_trig_edge.sv */
`timescale 1ns/10ps
`default_nettype none

module adcc_trig_edge
  import adcc_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic external_trigger_pin,
  output logic      trig_rise
);

  logic pin_d_r;
  logic pin_d_nxt;

  // pin is synchronous to hclk, so one delay stage is enough
  always_comb begin
    pin_d_nxt = external_trigger_pin;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= pin_d_nxt;
    end
  end

  // a pin already high at reset release counts as an edge
  assign trig_rise = external_trigger_pin & ~pin_d_r;

endmodule

`default_nettype wire

/* core/adcc_ahb_slave.sv */
`timescale 1ns/10ps
`default_nettype none

module adcc_ahb_slave
  import adcc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] rdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_en,
  output adcc_idx_t        reg_idx
);

  logic        wr_r, wr_nxt;
  logic        rd_r, rd_nxt;
  adcc_idx_t   idx_r, idx_nxt;
  logic        rdy_r, rdy_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        take;

  // reads spend one wait state so a write just before is always seen
  always_comb begin
    take     = hsel & htrans[1] & hready & (hsize == `ADCC_HSIZE_WORD);
    wr_nxt   = take & hwrite;
    rd_nxt   = take & ~hwrite;
    idx_nxt  = take ? haddr[9:2] : idx_r;
    rdy_nxt  = ~rd_nxt;
    rdat_nxt = rd_r ? rdata : rdat_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
      idx_r  <= 8'h00;
      rdy_r  <= 1'b1;
      rdat_r <= 32'h00000000;
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      idx_r  <= idx_nxt;
      rdy_r  <= rdy_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign hreadyout = rdy_r;
  assign hresp     = `ADCC_HRESP_OKAY;
  assign hrdata    = rdat_r;
  assign wr_en     = wr_r;
  assign reg_idx   = idx_r;

endmodule

`default_nettype wire

/* sim/adcc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adcc_params.svh"

module adcc_top_tb
  import adcc_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        external_trigger_pin;
  logic        conv_done_i;
  logic [9:0]  conv_result_i;
  logic        conv_start;
  logic [1:0]  conv_channel;
  logic        converter_clock_select;
  logic        irq;
  int          n_mismatch;
  int          n_checks;
  int          n_start;
  int          cycles;
  int          s0;

  localparam logic [31:0] A_CTRL = {22'h0, `ADCC_IDX_CTRL, 2'h0};
  localparam logic [31:0] A_RESH = {22'h0, `ADCC_IDX_RESH, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, `ADCC_IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] A_MASK = {22'h0, `ADCC_IDX_IRQ_MASK, 2'h0};
  localparam logic [31:0] A_NONE = {22'h0, 8'hE3, 2'h0};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  adcc_top u_dut (
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hready),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .hrdata                 (hrdata),
    .external_trigger_pin   (external_trigger_pin),
    .conv_done_i            (conv_done_i),
    .conv_result_i          (conv_result_i),
    .conv_start             (conv_start),
    .conv_channel           (conv_channel),
    .converter_clock_select (converter_clock_select),
    .irq                    (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, start pulse counter and hang guard
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // counting pulses avoids racing the one-cycle start strobe
  always @(posedge hclk) begin
    cycles++;
    if (conv_start === 1'b1) n_start++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready and read data are taken at the rising edge, as the slave sees them
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= `ADCC_HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask

  // result valid only in the strobe cycle, scrambled afterwards
  task automatic finish_conv(input logic [9:0] r);
    @(posedge hclk);
    conv_done_i   <= 1'b1;
    conv_result_i <= r;
    @(posedge hclk);
    conv_done_i   <= 1'b0;
    conv_result_i <= ~r;
  endtask

  task automatic trig();
    @(posedge hclk);
    external_trigger_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    external_trigger_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk("irq", 32'h0, {31'h0, irq});
    chk("channel", 32'h0, {30'h0, conv_channel});
    chk("hresp", 32'h0, {31'h0, hresp});
    rd_chk("ctrl", A_CTRL, 32'h00);
    rd_chk("result high", A_RESH, 32'h00);
    rd_chk("status", A_STAT, 32'h00);
    rd_chk("mask", A_MASK, 32'h00);
    $display("test reset done");
  endtask

  task automatic t_channels();
    for (int i = 0; i < 8; i++) begin
      wr(A_CTRL, i);
      @(negedge hclk);
      chk("channel", {30'h0, i[1:0]}, {30'h0, conv_channel});
      chk("clock select", {31'h0, i[2]}, {31'h0, converter_clock_select});
    end
    rd_chk("ctrl idle", A_CTRL, 32'h07);
    $display("test channels done");
  endtask

  task automatic t_convert();
    wr(A_MASK, 32'h1);
    s0 = n_start;
    wr(A_CTRL, 32'h0A);
    @(negedge hclk);
    chk("start pulse", 32'h1, {31'h0, conv_start});
    chk("channel", 32'h2, {30'h0, conv_channel});
    @(negedge hclk);
    chk("start width", 32'h0, {31'h0, conv_start});
    rd_chk("ctrl busy", A_CTRL, 32'h0A);
    wr(A_CTRL, 32'h01);
    rd_chk("ctrl after zero", A_CTRL, 32'h0A);
    wr(A_CTRL, 32'h0B);
    repeat (2) @(negedge hclk);
    chk("starts while busy", s0 + 1, n_start);
    chk("held channel", 32'h2, {30'h0, conv_channel});
    rd_chk("status refused", A_STAT, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    finish_conv(10'h2B5);
    @(negedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("ctrl done", A_CTRL, 32'h52);
    rd_chk("result high", A_RESH, 32'hAD);
    rd_chk("status", A_STAT, 32'h3);
    $display("test convert done");
  endtask

  task automatic t_done_block();
    s0 = n_start;
    wr(A_CTRL, 32'h1B);
    repeat (2) @(negedge hclk);
    chk("starts while done", s0, n_start);
    chk("channel", 32'h2, {30'h0, conv_channel});
    rd_chk("ctrl done kept", A_CTRL, 32'h52);
    wr(A_STAT, 32'h3);
    @(negedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(A_CTRL, 32'h0B);
    repeat (2) @(negedge hclk);
    chk("combined start", s0 + 1, n_start);
    chk("same channel", 32'h2, {30'h0, conv_channel});
    finish_conv(10'h3FF);
    rd_chk("result high", A_RESH, 32'hFF);
    rd_chk("ctrl", A_CTRL, 32'hD2);
    $display("test done block done");
  endtask

  task automatic t_trigger();
    wr(A_CTRL, 32'h22);
    s0 = n_start;
    trig();
    chk("trigger start", s0 + 1, n_start);
    trig();
    chk("trigger while busy", s0 + 1, n_start);
    finish_conv(10'h001);
    @(negedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(A_MASK, 32'h0);
    @(negedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_STAT, 32'h3);
    wr(A_CTRL, 32'h02);
    s0 = n_start;
    trig();
    chk("trigger disabled", s0, n_start);
    wr(A_CTRL, 32'h12);
    rd_chk("ctrl done not set", A_CTRL, 32'h42);
    wr(A_NONE, 32'hFF);
    rd_chk("unmapped", A_NONE, 32'h0);
    rd_chk("ctrl kept", A_CTRL, 32'h42);
    s0 = n_start;
    wr(A_CTRL, 32'h0A);
    repeat (2) @(negedge hclk);
    chk("start after clear", s0 + 1, n_start);
    $display("test trigger done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and main sequence
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    hresetn              = 1'b0;
    hsel                 = 1'b0;
    haddr                = 32'h0;
    htrans               = 2'h0;
    hwrite               = 1'b0;
    hsize                = 3'h0;
    hwdata               = 32'h0;
    external_trigger_pin = 1'b0;
    conv_done_i          = 1'b0;
    conv_result_i        = 10'h000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_channels();
    t_convert();
    t_done_block();
    t_trigger();
    finish_test();
  end
endmodule

`default_nettype wire
